// ==== rtl/mds_dwell_timer.sv ====
`timescale 1ns/1ns
module mds_dwell_timer #(
  parameter int TICK_CYCLES = mds_pkg::DWELL_TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [7:0] units,
  output logic            done
);
  import mds_pkg::*;

  logic [31:0] pre_reg;
  logic [7:0]  left_reg;
  logic        busy_reg;
  logic        done_reg;
  wire         tick = (pre_reg == 32'(TICK_CYCLES - 1));

  // prescaler and unit countdown; zero units finish on the next edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pre_reg  <= 32'h0;
      left_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (load)
      begin
        pre_reg  <= 32'h0;
        left_reg <= units;
        busy_reg <= 1'b1;
      end
      else if (busy_reg && left_reg == 8'h00)
      begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
        if (tick)
          left_reg <= left_reg - 8'h01;
      end
    end
  end

  assign done = done_reg;
endmodule : mds_dwell_timer

// ==== rtl/mds_irq.sv ====
`timescale 1ns/1ns
module mds_irq (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [mds_pkg::EV_NUM-1:0] events,
  input  wire logic                       wr_status,
  input  wire logic                       wr_mask,
  input  wire logic [mds_pkg::EV_NUM-1:0] wdata,
  output logic      [mds_pkg::EV_NUM-1:0] status,
  output logic      [mds_pkg::EV_NUM-1:0] mask,
  output logic                            irq
);
  import mds_pkg::*;

  logic [EV_NUM-1:0] status_reg;
  logic [EV_NUM-1:0] mask_reg;
  wire  [EV_NUM-1:0] clr = wr_status ? wdata : '0;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      status_reg <= '0;
      mask_reg   <= '0;
    end
    else
    begin
      status_reg <= (status_reg & ~clr) | events;
      if (wr_mask)
        mask_reg <= wdata;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = |(status_reg & mask_reg);
endmodule : mds_irq

// ==== rtl/mds_pkg.sv ====
package mds_pkg;
  // entry word layout
  localparam int FN_LSB    = 0;
  localparam int DIR_BIT   = 2;
  localparam int ACC_LSB   = 8;
  localparam int DEC_LSB   = 16;
  localparam int DWELL_LSB = 24;

  // operation function codes
  localparam logic [1:0] FN_SINGLE               = 2'h0;
  localparam logic [1:0] FN_LINKED               = 2'h1;
  localparam logic [1:0] FN_CHAINED_DWELL_FUNCTION = 2'h2;
  localparam logic [1:0] FN_PUSH                 = 2'h3;

  localparam logic [5:0] LAST_ENTRY = 6'h3F;
  localparam logic [2:0] MAX_CHAIN  = 3'h4;
  localparam logic [2:0] LEN_ONE    = 3'h1;

  // apb byte offsets
  localparam logic [7:0] OFS_ENTRY_INDEX = 8'h00;
  localparam logic [7:0] OFS_ENTRY_DATA  = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h10;

  // interrupt events
  localparam int EV_DONE  = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_SEG   = 2;
  localparam int EV_NUM   = 3;

  // dwell tick: one dwell unit is 10 ms
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DWELL_UNIT_NS  = 10000000;
  localparam int DWELL_TICK_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SCAN  = 5'h02,
    ST_RUN   = 5'h04,
    ST_DWELL = 5'h08,
    ST_ALARM = 5'h10
  } mds_state_t;
endpackage : mds_pkg

// ==== rtl/mds_sequencer.sv ====
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module mds_sequencer #(
  parameter int DWELL_TICK_CYCLES = mds_pkg::DWELL_TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic [5:0] entry_select_inputs,
  input  wire logic       start,
  input  wire logic       seg_done,
  output logic            ready,
  output logic            motion,
  output logic            alarm,
  output logic            abort,
  output logic            seg_start,
  output logic [5:0]      seg_entry,
  output logic            seg_dir,
  output logic [7:0]      seg_accel,
  output logic [7:0]      seg_decel,
  output logic            seg_blend,
  output logic            seg_push_start,
  output logic            irq
);
  import mds_pkg::*;

  function automatic logic [1:0] fn_of(input logic [31:0] w);
    fn_of = w[FN_LSB +: 2];
  endfunction : fn_of

  // a linked or dwell entry chains on unless it is the last number in the table
  function automatic logic chains(input logic [31:0] w, input logic [5:0] idx);
    chains = (fn_of(w) == FN_LINKED || fn_of(w) == FN_CHAINED_DWELL_FUNCTION)
             && idx != LAST_ENTRY;
  endfunction : chains

  logic [31:0]  entry_mem [0:63];
  mds_state_t   state_reg, state_next;
  logic [5:0]   cur_reg, cur_next, scan_reg, scan_next, index_reg;
  logic [2:0]   len_reg, len_next;
  logic         ready_reg, ready_next, motion_reg, motion_next;
  logic         start_prev_reg, abort_reg, seg_start_reg;
  logic [5:0]   seg_entry_reg;
  logic         seg_dir_reg, seg_blend_reg, seg_push_reg;
  logic [7:0]   acc_reg, dec_reg;
  logic         issue, alarm_evt, done_evt, dwell_load, dwell_done;
  logic [5:0]   issue_idx;
  logic [EV_NUM-1:0] irq_status, irq_mask;

  // bus decode; every access completes with no wait state
  wire          acc_phase  = psel && penable;
  wire          wr_en      = acc_phase && pwrite;
  wire          hit_index  = (paddr == OFS_ENTRY_INDEX);
  wire          hit_data   = (paddr == OFS_ENTRY_DATA);
  wire          hit_status = (paddr == OFS_STATUS);
  wire          hit_istat  = (paddr == OFS_IRQ_STATUS);
  wire          hit_imask  = (paddr == OFS_IRQ_MASK);
  wire          mapped     = hit_index | hit_data | hit_status | hit_istat | hit_imask;
  wire [31:0]   status_word = {16'h0000, state_reg, len_reg, cur_reg, 2'h0};

  // sequencer views of the table
  wire [5:0]    sel_entry  = entry_select_inputs;
  wire          start_rise = start && !start_prev_reg;
  wire [31:0]   cur_word   = entry_mem[cur_reg];
  wire [31:0]   scan_word  = entry_mem[scan_reg];
  wire [5:0]    nxt_idx    = cur_reg + 6'h01;
  wire [31:0]   nxt_word   = entry_mem[nxt_idx];
  wire [31:0]   issue_word = entry_mem[issue_idx];
  wire          dir_differs = cur_word[DIR_BIT] != nxt_word[DIR_BIT];

  assign pready  = 1'b1;
  assign pslverr = acc_phase && !mapped;

  // table writes go through the index register
  always_ff @(posedge clk)
  begin
    if (wr_en && hit_data)
      entry_mem[index_reg] <= pwdata;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      index_reg <= 6'h00;
    else if (wr_en && hit_index)
      index_reg <= pwdata[5:0];
  end

  // read data is registered at the setup phase so it stands in the access phase
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= hit_index  ? {26'h0, index_reg} :
                hit_data   ? entry_mem[index_reg] :
                hit_status ? status_word :
                hit_istat  ? {29'h0, irq_status} :
                hit_imask  ? {29'h0, irq_mask} : 32'h0;
  end

  // next-state logic of the chain walker
  always_comb
  begin
    state_next  = state_reg;
    cur_next    = cur_reg;
    scan_next   = scan_reg;
    len_next    = len_reg;
    ready_next  = ready_reg;
    motion_next = motion_reg;
    issue       = 1'b0;
    issue_idx   = cur_reg;
    alarm_evt   = 1'b0;
    done_evt    = 1'b0;
    dwell_load  = 1'b0;
    unique case (state_reg)
      ST_IDLE:
        if (start_rise && ready_reg)
        begin
          cur_next   = sel_entry;
          scan_next  = sel_entry;
          len_next   = LEN_ONE;
          ready_next = 1'b0;
          state_next = ST_SCAN;
        end
      ST_SCAN:
        // walk the whole chain before moving so an overlong one never starts
        if (chains(scan_word, scan_reg))
        begin
          if (len_reg == MAX_CHAIN)
            alarm_evt = 1'b1;
          else
          begin
            scan_next = scan_reg + 6'h01;
            len_next  = len_reg + 3'h1;
          end
        end
        else
        begin
          issue       = 1'b1;
          motion_next = 1'b1;
          state_next  = ST_RUN;
        end
      ST_RUN:
        if (seg_done)
        begin
          if (fn_of(cur_word) == FN_LINKED && chains(cur_word, cur_reg))
          begin
            if (dir_differs)
              alarm_evt = 1'b1;
            else
            begin
              cur_next  = nxt_idx;
              issue     = 1'b1;
              issue_idx = nxt_idx;
            end
          end
          else if (chains(cur_word, cur_reg))
          begin
            motion_next = 1'b0;
            dwell_load  = 1'b1;
            state_next  = ST_DWELL;
          end
          else
          begin
            motion_next = 1'b0;
            ready_next  = 1'b1;
            done_evt    = 1'b1;
            state_next  = ST_IDLE;
          end
        end
      ST_DWELL:
        if (dwell_done)
        begin
          cur_next    = nxt_idx;
          issue       = 1'b1;
          issue_idx   = nxt_idx;
          motion_next = 1'b1;
          state_next  = ST_RUN;
        end
      ST_ALARM:
        ready_next = 1'b0;
      default:
        alarm_evt = 1'b1;
    endcase
    if (alarm_evt)
    begin
      state_next  = ST_ALARM;
      motion_next = 1'b0;
      ready_next  = 1'b0;
    end
  end

  // control registers; reset sets ready, so it is already high while reset is held
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg      <= ST_IDLE;
      cur_reg        <= 6'h00;
      scan_reg       <= 6'h00;
      len_reg        <= 3'h0;
      ready_reg      <= 1'b1;
      motion_reg     <= 1'b0;
      start_prev_reg <= 1'b0;
      abort_reg      <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      cur_reg        <= cur_next;
      scan_reg       <= scan_next;
      len_reg        <= len_next;
      ready_reg      <= ready_next;
      motion_reg     <= motion_next;
      start_prev_reg <= start;
      abort_reg      <= alarm_evt;
    end
  end

  // ramp rates are latched once per start and held for the chain
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      acc_reg <= 8'h00;
      dec_reg <= 8'h00;
    end
    else if (state_reg == ST_IDLE && start_rise && ready_reg)
    begin
      acc_reg <= entry_mem[sel_entry][ACC_LSB +: 8];
      dec_reg <= entry_mem[sel_entry][DEC_LSB +: 8];
    end
  end

  // segment command to the motion engine
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      seg_start_reg <= 1'b0;
      seg_entry_reg <= 6'h00;
      seg_dir_reg   <= 1'b0;
      seg_blend_reg <= 1'b0;
      seg_push_reg  <= 1'b0;
    end
    else
    begin
      seg_start_reg <= issue;
      if (issue)
      begin
        seg_entry_reg <= issue_idx;
        seg_dir_reg   <= issue_word[DIR_BIT];
        seg_blend_reg <= chains(issue_word, issue_idx) && fn_of(issue_word) == FN_LINKED;
        seg_push_reg  <= fn_of(issue_word) == FN_PUSH && len_reg > LEN_ONE;
      end
    end
  end

  mds_dwell_timer #(
    .TICK_CYCLES (DWELL_TICK_CYCLES)
  ) u_dwell (
    .clk   (clk),
    .reset (reset),
    .load  (dwell_load),
    .units (cur_word[DWELL_LSB +: 8]),
    .done  (dwell_done)
  );

  mds_irq u_irq (
    .clk       (clk),
    .reset     (reset),
    .events    ({seg_done && state_reg == ST_RUN, alarm_evt, done_evt}),
    .wr_status (wr_en && hit_istat),
    .wr_mask   (wr_en && hit_imask),
    .wdata     (pwdata[EV_NUM-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  assign ready          = ready_reg;
  assign motion         = motion_reg;
  assign alarm          = (state_reg == ST_ALARM);
  assign abort          = abort_reg;
  assign seg_start      = seg_start_reg;
  assign seg_entry      = seg_entry_reg;
  assign seg_dir        = seg_dir_reg;
  assign seg_accel      = acc_reg;
  assign seg_decel      = dec_reg;
  assign seg_blend      = seg_blend_reg;
  assign seg_push_start = seg_push_reg;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  wire run_done = state_reg == ST_RUN && seg_done;
  wire lnk_cur  = fn_of(cur_word) == FN_LINKED && chains(cur_word, cur_reg);

  a_ready_drop: assert property (
    state_reg == ST_IDLE && ready_reg && start_rise |=> !ready ##1 !ready)
    else $error("ready did not drop on start");
  a_select_map: assert property (
    state_reg == ST_IDLE && ready_reg && start_rise |=> cur_reg == $past(entry_select_inputs))
    else $error("entry number not taken from select inputs");
  a_chain_limit: assert property (
    state_reg == ST_SCAN && len_reg == MAX_CHAIN && chains(scan_word, scan_reg)
    |=> alarm && !motion && abort)
    else $error("overlong chain not refused");
  a_dir_check: assert property (
    run_done && lnk_cur && dir_differs |=> alarm && !motion)
    else $error("direction change in linked chain not flagged");
  a_link_flow: assert property (
    run_done && lnk_cur && !dir_differs
    |=> seg_start && motion && seg_entry == $past(cur_reg) + 6'h01)
    else $error("linked segment did not flow on");
  a_single_stop: assert property (
    run_done && !chains(cur_word, cur_reg) |=> ready && !motion && !seg_start)
    else $error("chain end did not stop");
  a_last_alone: assert property (
    run_done && cur_reg == LAST_ENTRY |=> state_reg == ST_IDLE)
    else $error("entry 63 chained onward");
  a_ramp_hold: assert property (
    seg_start && state_reg == ST_RUN && $past(state_reg) == ST_RUN |-> $stable(seg_accel))
    else $error("ramp changed inside chain");
  a_dwell_gap: assert property (
    state_reg == ST_DWELL |-> !motion && !ready)
    else $error("motion high during dwell");
  a_dwell_resume: assert property (
    state_reg == ST_DWELL && dwell_done |=> motion && seg_start)
    else $error("next segment did not start after dwell");
  a_alarm_hold: assert property (
    alarm |=> alarm && !ready && !motion)
    else $error("alarm released before reset");

  c_single: cover property (run_done && !chains(cur_word, cur_reg) && len_reg == LEN_ONE);
  c_dwell:  cover property (state_reg == ST_DWELL ##[1:20] seg_start);
  c_alarm:  cover property (state_reg == ST_SCAN ##1 alarm);
endmodule : mds_sequencer

// ==== sim/mds_host_model.sv ====
`timescale 1ns/1ns
module mds_host_model (
  input  wire logic       clk,
  input  wire logic       ready,
  input  wire logic       seg_start,
  output logic      [5:0] entry_select_inputs,
  output logic            start,
  output logic            seg_done
);
  int seg_cycles = 3;
  int segs = 0;

  // host lines idle low before the first request
  initial
  begin
    entry_select_inputs = 6'h00;
    start = 1'b0;
    seg_done = 1'b0;
  end

  // select settles an edge ahead of start; start drops once ready falls
  task automatic launch(input logic [5:0] num);
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    entry_select_inputs <= num;
    @(posedge clk);
    start <= 1'b1;
    do @(posedge clk); while (ready !== 1'b0);
    start <= 1'b0;
    entry_select_inputs <= ~num; // stale select must not leak into the run
  endtask : launch

  // motion engine: every segment command ends after seg_cycles edges
  always @(posedge clk)
  begin
    if (seg_start === 1'b1)
    begin
      segs <= segs + 1;
      repeat (seg_cycles) @(posedge clk);
      seg_done <= 1'b1;
      @(posedge clk);
      seg_done <= 1'b0;
    end
  end
endmodule : mds_host_model

// ==== sim/tb_mds_sequencer.sv ====
`timescale 1ns/1ns
module tb_mds_sequencer;
  import mds_pkg::*;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  sel;
  logic        start;
  logic        seg_done;
  logic        ready;
  logic        motion;
  logic        alarm;
  logic        abort;
  logic        seg_start;
  logic [5:0]  seg_entry;
  logic        seg_dir;
  logic [7:0]  seg_accel;
  logic [7:0]  seg_decel;
  logic        seg_blend;
  logic        seg_push_start;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          errors = 0;
  int          checked = 0;
  int          drops = 0;
  int          low_cyc = 0;
  int          aborts = 0;
  int          blends = 0;
  int          s0;
  int          d0;
  int          l0;

  // short dwell tick keeps the dwell scenarios brief
  mds_sequencer #(.DWELL_TICK_CYCLES(4)) DUT (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .entry_select_inputs(sel), .start, .seg_done, .ready, .motion, .alarm,
    .abort, .seg_start, .seg_entry, .seg_dir, .seg_accel, .seg_decel, .seg_blend,
    .seg_push_start, .irq
  );

  mds_host_model host (
    .clk, .ready, .seg_start, .entry_select_inputs(sel), .start, .seg_done
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // motion falls and stopped cycles inside an operation
  always @(posedge clk)
  begin
    if ($fell(motion)) drops <= drops + 1;
    if (ready === 1'b0 && motion === 1'b0) low_cyc <= low_cyc + 1;
    if (abort === 1'b1) aborts <= aborts + 1;
    if (seg_start === 1'b1 && seg_blend === 1'b1) blends <= blends + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; a leading edge keeps two transfers from colliding
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ent(logic [1:0] f, logic d, logic [7:0] ac, logic [7:0] dw);
    return {dw, ac ^ 8'hFF, ac, 5'h00, d, f};
  endfunction : ent

  task automatic put(input logic [5:0] n, input logic [31:0] w);
    apb(1'b1, OFS_ENTRY_INDEX, {26'h0, n});
    apb(1'b1, OFS_ENTRY_DATA, w);
  endtask : put

  // entry table used by every scenario
  task automatic fill;
    put(6'h00, ent(FN_SINGLE, 1'b0, 8'h01, 8'h00));
    put(6'h01, ent(FN_SINGLE, 1'b0, 8'h21, 8'h00));
    put(6'h25, ent(FN_SINGLE, 1'b1, 8'h25, 8'h00));
    for (int i = 2; i < 5; i++) put(i[5:0], ent(FN_LINKED, 1'b0, 8'h10 + 8'(i), 8'h00));
    put(6'h05, ent(FN_SINGLE, 1'b0, 8'h55, 8'h00));
    put(6'h0A, ent(FN_CHAINED_DWELL_FUNCTION, 1'b0, 8'h0A, 8'h02));
    put(6'h0B, ent(FN_CHAINED_DWELL_FUNCTION, 1'b1, 8'h0B, 8'h03));
    put(6'h0C, ent(FN_SINGLE, 1'b0, 8'h0C, 8'h00));
    put(6'h14, ent(FN_LINKED, 1'b1, 8'h14, 8'h00));
    put(6'h15, ent(FN_PUSH, 1'b1, 8'h15, 8'h00));
    put(6'h3F, ent(FN_LINKED, 1'b0, 8'h3F, 8'h00));
    put(6'h1E, ent(FN_LINKED, 1'b0, 8'h1E, 8'h00));
    put(6'h1F, ent(FN_SINGLE, 1'b1, 8'h1F, 8'h00));
    for (int i = 40; i < 44; i++) put(i[5:0], ent(FN_LINKED, 1'b0, 8'h28, 8'h00));
    put(6'h2C, ent(FN_SINGLE, 1'b0, 8'h2C, 8'h00));
  endtask : fill

  task automatic do_reset;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    fill();
  endtask : do_reset

  // run one operation and wait for completion or the alarm
  task automatic go(input logic [5:0] n);
    s0 = host.segs;
    d0 = drops;
    l0 = low_cyc;
    host.launch(n);
    for (int i = 0; i < 600 && ready !== 1'b1 && alarm !== 1'b1; i++) @(posedge clk);
    // an operation that never ends counts against the run
    chk(32'(ready === 1'b1 || alarm === 1'b1), 32'h1);
    repeat (2) @(posedge clk);
  endtask : go

  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // watchdog: the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    do_reset();
    chk(32'({ready, motion, alarm, irq}), 32'h8);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    // single move, then the interrupt path with mask off and on
    go(6'h01);
    chk(32'(host.segs - s0), 32'h1);
    chk(32'(drops - d0), 32'h1);
    chk(32'({ready, seg_entry}), 32'h41);
    chk(32'(irq), 32'h0);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, OFS_IRQ_MASK, 32'h7);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    go(6'h25);
    chk(32'({seg_dir, seg_entry}), 32'h65);
    // three linked entries and a single: the longest legal chain, no stop between
    go(6'h02);
    chk(32'(host.segs - s0), 32'h4);
    chk(32'(drops - d0), 32'h1);
    chk(32'({alarm, seg_entry}), 32'h05);
    chk(32'({seg_accel, seg_decel}), 32'h12ED);
    chk(32'(blends), 32'h3);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h00000C14);
    // dwell chain with a direction change and a slow motion engine
    host.seg_cycles = 12;
    go(6'h0A);
    host.seg_cycles = 3;
    chk(32'(host.segs - s0), 32'h3);
    chk(32'(drops - d0), 32'h3);
    chk(32'(low_cyc - l0 >= 20 && low_cyc - l0 <= 34), 32'h1);
    chk(32'(alarm), 32'h0);
    go(6'h14);
    chk(32'(host.segs - s0), 32'h2);
    chk(32'(seg_push_start), 32'h1);
    go(6'h3F);
    chk(32'(host.segs - s0), 32'h1);
    chk(32'({alarm, seg_entry}), 32'h3F);
    // direction change on a plain link must abort
    go(6'h1E);
    chk(32'(alarm), 32'h1);
    chk(32'(aborts), 32'h1);
    repeat (20) @(posedge clk);
    chk(32'({ready, motion, alarm}), 32'h1);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    chk(32'(rd[1]), 32'h1);
    do_reset();
    chk(32'({ready, alarm}), 32'h2);
    // five chained entries are refused at start
    go(6'h28);
    chk(32'(alarm), 32'h1);
    chk(32'(aborts), 32'h2);
    chk(32'(host.segs - s0), 32'h0);
    report_and_stop();
  end
endmodule : tb_mds_sequencer
